/* File: core/i2c_multimaster_sequencer.v */
/* i2c_multimaster_sequencer.v: byte-level i2c master/slave sequencer with apb register port.
   assumes open-drain pads outside (oe high pulls the line low), pull-ups on both lines,
   an apb master on mclk_i, and a divider limit of at least 5 so data moves on the sensed fall
   before the next tick lets SCL go; at 4 both change in the same cycle. */
`timescale 1ns/1ps
`include "i2c_defs.vh"
module i2c_multimaster_sequencer (
   input  wire        mclk_i,
   input  wire        rstn_i,
   input  wire        psel_i,
   input  wire        penable_i,
   input  wire        pwrite_i,
   input  wire [7:0]  paddr_i,
   input  wire [31:0] pwdata_i,
   output wire [31:0] prdata_o,
   output wire        pready_o,
   output wire        pslverr_o,
   input  wire        sda_i,
   output wire        sda_o,
   output wire        sda_oe_o,
   input  wire        scl_i,
   output wire        scl_o,
   output wire        scl_oe_o,
   output wire        pin_mux_o,
   output wire        irq_o
);
   localparam S_IDLE  = 3'd0;
   localparam S_BYTE  = 3'd1;
   localparam S_WAIT  = 3'd2;
   localparam S_START = 3'd3;
   localparam S_STOP  = 3'd4;
   localparam S_MIDLE = 3'd5;
   localparam W_SR1   = 2'd0;
   localparam W_DRR   = 2'd1;
   localparam W_DRW   = 2'd2;
   localparam W_CRW   = 2'd3;

   // apb and control registers
   reg        pready_ff, pslverr_ff, irq_ff, mux_ff, zero_ff;
   reg [31:0] prdata_ff;
   reg [31:0] rdmux;
   reg        on_ff, engc_ff, ack_ff, ite_ff, start_ff, stop_ff;
   reg [7:0]  oar1_ff, own_address_two_ff, div_ff, dr_ff, sh_ff;
   // status flags
   reg        ten_bit_header_sent_ff, tra_ff, busy_ff, btf_ff, own_address_hit_ff, msl_ff, sb_ff, ev6_ff;
   reg        af_ff, end_detected_flag_ff, arbitration_lost_flag_ff, misplaced_condition_error_ff, gcal_ff;
   // sequencing state
   reg [2:0]  state_ff;
   reg [1:0]  wk_ff, step_ff;
   reg [3:0]  bit_ff;
   reg        sda_oe_ff, scl_oe_ff, sr1s_ff, samp_ff, nack_ff, skip_ff;
   reg        aph_ff, dir_ff, madr_ff, m10h_ff, hdr10_ff, hit10_ff, hitp_ff, gcp_ff;
   reg        slv_act_ff, supp_ff;

   wire sda_s, scl_s, scl_rise, scl_fall, start_p, stop_p, tick;

   i2c_line_sync u_sync (
      .mclk_i     (mclk_i),
      .rstn_i     (rstn_i),
      .sda_i      (sda_i),
      .scl_i      (scl_i),
      .sda_s_o    (sda_s),
      .scl_s_o    (scl_s),
      .scl_rise_o (scl_rise),
      .scl_fall_o (scl_fall),
      .start_o    (start_p),
      .stop_o     (stop_p)
   );

   // fast mode uses the setting as is, standard mode four times slower
   wire       fast = own_address_two_ff[`OWN_ADDRESS_TWO_FAST];
   wire [9:0] lim  = fast ? {2'b00, div_ff} : {div_ff, 2'b00};
   wire       own  = (state_ff == S_START) || (state_ff == S_STOP);

   i2c_scl_divider u_div (
      .mclk_i (mclk_i),
      .rstn_i (rstn_i),
      .en_i   (msl_ff | own),
      .lim_i  (lim),
      .tick_o (tick)
   );

   // bus decode: request is taken in the access cycle, which is always the first one
   wire acc    = psel_i & penable_i & pready_ff;
   wire wr     = acc & pwrite_i;
   wire rd     = acc & ~pwrite_i;
   wire wr_cr  = wr & (paddr_i == `CR_ADDR);
   wire wr_dr  = wr & (paddr_i == `DR_ADDR);
   wire rd_sr1 = rd & (paddr_i == `SR1_ADDR);
   wire rd_sr2 = rd & (paddr_i == `SR2_ADDR);
   wire rd_dr  = rd & (paddr_i == `DR_ADDR);
   wire [7:0] wb = pwdata_i[7:0];
   wire ten    = own_address_two_ff[`OWN_ADDRESS_TWO_TEN];
   wire tx     = madr_ff | (dir_ff & ~aph_ff);
   wire any_event_flag    = btf_ff | own_address_hit_ff | sb_ff | ten_bit_header_sent_ff | ev6_ff | af_ff | end_detected_flag_ff | arbitration_lost_flag_ff | misplaced_condition_error_ff;
   wire stop_fall = wr_cr & stop_ff & ~pwdata_i[`CR_STOP];

   // address comparison on the byte as it completes
   wire [7:0] abyte = {sh_ff[6:0], samp_ff};
   wire hdr_m = (abyte[7:3] == `HDR_PAT) && (abyte[2:1] == own_address_two_ff[2:1]);
   wire m10_2 = ten & hdr10_ff & (abyte == oar1_ff);
   wire m10_h = ten & ~hdr10_ff & hdr_m & ~abyte[0];
   wire m10_r = ten & ~hdr10_ff & hdr_m & abyte[0] & hit10_ff;
   wire m7    = ~ten & (abyte[7:1] == oar1_ff[7:1]);
   wire mgc   = engc_ff & (abyte == `GC_ADDR);
   wire ahit  = m10_2 | m10_r | m7 | mgc;

   // cpu completes a stretched event with the documented access pair; an address hit needs only the status one read
   wire rel = (state_ff == S_WAIT) & ((wk_ff == W_SR1 & rd_sr1) |
              (sr1s_ff & ((wk_ff == W_DRR & rd_dr) | (wk_ff == W_DRW & wr_dr) |
              (wk_ff == W_CRW & wr_cr))));

   // read mux; unmapped addresses read zero and answer with pslverr
   always @* begin
      case (paddr_i)
         `CR_ADDR:   rdmux = {26'h0, on_ff, engc_ff, start_ff, ack_ff, stop_ff, ite_ff};
         `SR1_ADDR:  rdmux = {24'h0, any_event_flag, ten_bit_header_sent_ff, tra_ff, busy_ff, btf_ff, own_address_hit_ff, msl_ff, sb_ff};
         `SR2_ADDR:  rdmux = {27'h0, af_ff, end_detected_flag_ff, arbitration_lost_flag_ff, misplaced_condition_error_ff, gcal_ff};
         `DR_ADDR:   rdmux = {24'h0, dr_ff};
         `OAR1_ADDR: rdmux = {24'h0, oar1_ff};
         `OWN_ADDRESS_TWO_ADDR: rdmux = {24'h0, own_address_two_ff};
         `DIV_ADDR:  rdmux = {24'h0, div_ff};
         default:    rdmux = 32'h0;
      endcase
   end

   // apb answer, configuration registers, pin ownership and interrupt
   always @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff  <= 32'h0;
         {on_ff, engc_ff, ack_ff, ite_ff, irq_ff, mux_ff, zero_ff} <= 7'h00;
         oar1_ff <= `OAR_RST;
         own_address_two_ff <= `OAR_RST;
         div_ff  <= `DIV_RST;
      end else begin
         pready_ff  <= psel_i & ~penable_i;
         pslverr_ff <= psel_i & ~penable_i & (paddr_i > `DIV_ADDR || paddr_i[1:0] != 2'b00);
         prdata_ff  <= (psel_i & ~penable_i & ~pwrite_i) ? rdmux : 32'h0;
         // the first write with the enable bit only switches the interface on
         if (wr_cr) begin
            on_ff <= pwdata_i[`CR_ON];
            if (on_ff) begin
               engc_ff <= pwdata_i[`CR_ENGC];
               ack_ff  <= pwdata_i[`CR_ACK];
               ite_ff  <= pwdata_i[`CR_ITE];
            end
         end else if (!on_ff) begin
            {engc_ff, ack_ff, ite_ff} <= 3'h0;
         end
         if (wr & (paddr_i == `OAR1_ADDR)) oar1_ff <= wb;
         if (wr & (paddr_i == `OWN_ADDRESS_TWO_ADDR)) own_address_two_ff <= wb;
         if (wr & (paddr_i == `DIV_ADDR))  div_ff <= wb;
         mux_ff <= on_ff;
         irq_ff <= any_event_flag & ite_ff & on_ff;
      end
   end

   // byte sequencer
   always @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state_ff <= S_IDLE;
         {wk_ff, step_ff, bit_ff} <= 8'h00;
         {start_ff, stop_ff, dr_ff, sh_ff} <= 18'h0;
         {ten_bit_header_sent_ff, tra_ff, busy_ff, btf_ff, own_address_hit_ff, msl_ff, sb_ff, ev6_ff} <= 8'h00;
         {af_ff, end_detected_flag_ff, arbitration_lost_flag_ff, misplaced_condition_error_ff, gcal_ff} <= 5'h00;
         {sda_oe_ff, scl_oe_ff, sr1s_ff, samp_ff, nack_ff, skip_ff} <= 6'h00;
         {aph_ff, dir_ff, madr_ff, m10h_ff, hdr10_ff, hit10_ff, hitp_ff, gcp_ff} <= 8'h00;
         {slv_act_ff, supp_ff} <= 2'b00;
      end else if (!on_ff) begin
         // disabled: lines released and flags and start cleared; data, bit counter and the stop request are not cleared
         state_ff <= S_IDLE;
         start_ff <= 1'b0;
         if (wr_cr) stop_ff <= pwdata_i[`CR_STOP];
         {ten_bit_header_sent_ff, tra_ff, busy_ff, btf_ff, own_address_hit_ff, msl_ff, sb_ff, ev6_ff} <= 8'h00;
         {af_ff, end_detected_flag_ff, arbitration_lost_flag_ff, misplaced_condition_error_ff, gcal_ff} <= 5'h00;
         {sda_oe_ff, scl_oe_ff, aph_ff, dir_ff, madr_ff, m10h_ff} <= 6'h00;
         {hdr10_ff, hit10_ff, slv_act_ff, supp_ff} <= 4'h0;
      end else begin
         if (wr_cr) begin
            start_ff <= pwdata_i[`CR_START];
            stop_ff  <= pwdata_i[`CR_STOP];
         end
         if (wr_dr) dr_ff <= wb;
         // clears come first so a same-cycle event set below wins
         if (rd_sr1) af_ff <= 1'b0;
         if (rd_sr2) {end_detected_flag_ff, arbitration_lost_flag_ff, misplaced_condition_error_ff, gcal_ff} <= 4'h0;
         if (rd_sr1 && state_ff == S_WAIT) sr1s_ff <= 1'b1;
         if (!own) step_ff <= 2'd0;
         case (state_ff)
            S_IDLE: begin
               if (start_ff && !busy_ff && !msl_ff) state_ff <= S_START;
               // byte done left by a slave no reply clears by stop toggle or fill data
               if (btf_ff && (stop_fall || (wr_dr && wb == `FILL_DATA))) begin
                  btf_ff  <= 1'b0;
                  tra_ff  <= 1'b0;
                  supp_ff <= stop_fall;
               end
            end
            S_MIDLE: begin
               // master after no reply: software picks start or stop
               if (stop_ff) state_ff <= S_STOP;
               else if (start_ff) state_ff <= S_START;
            end
            S_START: if (tick) begin
               step_ff <= step_ff + 2'd1;
               case (step_ff)
                  2'd0: sda_oe_ff <= 1'b0;
                  2'd1: scl_oe_ff <= 1'b0;
                  2'd2: if (scl_s && sda_s) sda_oe_ff <= 1'b1; else step_ff <= 2'd2;
                  default: begin
                     scl_oe_ff <= 1'b1;
                     {sb_ff, msl_ff, busy_ff} <= 3'b111;
                     {start_ff, sr1s_ff, aph_ff, dir_ff, slv_act_ff} <= 5'h00;
                     wk_ff    <= W_DRW;
                     state_ff <= S_WAIT;
                  end
               endcase
            end
            S_STOP: if (tick) begin
               step_ff <= step_ff + 2'd1;
               case (step_ff)
                  2'd0: scl_oe_ff <= 1'b1;
                  2'd1: sda_oe_ff <= 1'b1;
                  2'd2: scl_oe_ff <= 1'b0;
                  default: if (scl_s) begin
                     sda_oe_ff <= 1'b0;
                     {msl_ff, stop_ff, dir_ff, tra_ff} <= 4'h0;
                     state_ff  <= S_IDLE;
                  end else begin
                     step_ff <= 2'd3;
                  end
               endcase
            end
            S_WAIT: begin
               if (rel) begin
                  sr1s_ff <= 1'b0;
                  bit_ff  <= 4'd0;
                  case (wk_ff)
                     W_SR1: begin
                        own_address_hit_ff <= 1'b0;
                        if (dir_ff) begin
                           wk_ff   <= W_DRW;
                           sr1s_ff <= 1'b1;
                        end else begin
                           state_ff <= S_BYTE;
                        end
                     end
                     W_DRW: begin
                        // the written byte goes out; bit 7 set up before SCL is let go
                        {btf_ff, tra_ff, sb_ff, ten_bit_header_sent_ff} <= 4'h0;
                        sh_ff     <= wb;
                        madr_ff   <= sb_ff | ten_bit_header_sent_ff;
                        sda_oe_ff <= ~wb[7];
                        state_ff  <= S_BYTE;
                        if (sb_ff) begin
                           dir_ff  <= ~wb[0];
                           m10h_ff <= ten & (wb[7:3] == `HDR_PAT) & ~wb[0];
                        end
                     end
                     W_CRW: begin
                        ev6_ff <= 1'b0;
                        if (stop_ff) state_ff <= S_STOP;
                        else if (start_ff) state_ff <= S_START;
                        else if (dir_ff) begin
                           wk_ff   <= W_DRW;
                           sr1s_ff <= 1'b1;
                        end else state_ff <= S_BYTE;
                     end
                     default: begin
                        {btf_ff, tra_ff} <= 2'b00;
                        // a stop set before the last read ends the master receive
                        if (msl_ff && stop_ff) state_ff <= S_STOP;
                        else if (msl_ff && start_ff) state_ff <= S_START;
                        else state_ff <= S_BYTE;
                     end
                  endcase
               end else if (wk_ff == W_DRW && btf_ff && msl_ff && (stop_ff || start_ff)) begin
                  {btf_ff, tra_ff} <= 2'b00;
                  state_ff <= stop_ff ? S_STOP : S_START;
               end else if (!msl_ff && btf_ff && stop_ff) begin
                  // slave lets go of both lines after the current byte
                  {btf_ff, tra_ff, scl_oe_ff} <= 3'b000;
                  supp_ff  <= 1'b1;
                  state_ff <= S_IDLE;
               end
            end
            S_BYTE: begin
               // master clock: low and high halves of one divider period each;
               // a release is followed only once SCL is seen high, so stretching works
               if (!msl_ff) scl_oe_ff <= 1'b0;
               else if (tick && scl_oe_ff) scl_oe_ff <= 1'b0;
               else if (tick && scl_s) scl_oe_ff <= 1'b1;
               if (scl_rise) begin
                  samp_ff <= sda_s;
                  if (bit_ff == 4'd8) nack_ff <= sda_s;
                  else if (tx && msl_ff && !sda_oe_ff && !sda_s) begin
                     arbitration_lost_flag_ff  <= 1'b1;
                     {msl_ff, tra_ff, madr_ff, scl_oe_ff} <= 4'h0;
                     state_ff <= S_IDLE;
                  end
               end
               if (scl_fall) begin
                  if (skip_ff) skip_ff <= 1'b0;
                  else if (bit_ff < 4'd7) begin
                     sh_ff     <= abyte;
                     bit_ff    <= bit_ff + 4'd1;
                     sda_oe_ff <= tx & ~sh_ff[6];
                  end else if (bit_ff == 4'd7) begin
                     sh_ff  <= abyte;
                     bit_ff <= 4'd8;
                     if (aph_ff) begin
                        if (ahit || m10_h) begin
                           sda_oe_ff <= ack_ff;
                           hitp_ff   <= ahit;
                           gcp_ff    <= mgc & ~m7;
                           hdr10_ff  <= m10_h;
                           dir_ff    <= m10_r | (m7 & abyte[0]);
                        end else begin
                           state_ff  <= S_IDLE;
                           aph_ff    <= 1'b0;
                           sda_oe_ff <= 1'b0;
                        end
                     end else begin
                        sda_oe_ff <= ~tx & ack_ff;
                     end
                  end else begin
                     bit_ff    <= 4'd0;
                     sda_oe_ff <= 1'b0;
                     if (aph_ff) begin
                        if (hitp_ff) begin
                           {own_address_hit_ff, slv_act_ff} <= 2'b11;
                           aph_ff    <= 1'b0;
                           gcal_ff   <= gcp_ff;
                           hit10_ff  <= ten;
                           hdr10_ff  <= 1'b0;
                           wk_ff     <= W_SR1;
                           sr1s_ff   <= 1'b0;
                           scl_oe_ff <= 1'b1;
                           state_ff  <= S_WAIT;
                        end
                     end else if (tx && nack_ff) begin
                        af_ff     <= 1'b1;
                        madr_ff   <= 1'b0;
                        scl_oe_ff <= 1'b0;
                        state_ff  <= msl_ff ? S_MIDLE : S_IDLE;
                        if (!msl_ff) {btf_ff, tra_ff} <= 2'b11;
                     end else begin
                        sr1s_ff   <= 1'b0;
                        scl_oe_ff <= 1'b1;
                        state_ff  <= S_WAIT;
                        if (madr_ff) begin
                           madr_ff  <= 1'b0;
                           m10h_ff  <= 1'b0;
                           ten_bit_header_sent_ff <= m10h_ff;
                           ev6_ff   <= ~m10h_ff;
                           wk_ff    <= m10h_ff ? W_DRW : W_CRW;
                        end else begin
                           btf_ff <= 1'b1;
                           tra_ff <= tx;
                           wk_ff  <= tx ? W_DRW : W_DRR;
                           if (!tx) dr_ff <= sh_ff;
                        end
                     end
                  end
               end
            end
            default: state_ff <= S_IDLE;
         endcase
         // foreign bus conditions take priority over the byte engine
         if (start_p && !own) begin
            busy_ff <= 1'b1;
            if (state_ff == S_BYTE && bit_ff != 4'd0) misplaced_condition_error_ff <= 1'b1;
            if (!msl_ff) begin
               state_ff <= S_BYTE;
               {aph_ff, skip_ff} <= 2'b11;
               {bit_ff, sda_oe_ff, scl_oe_ff, dir_ff, hdr10_ff} <= 8'h00;
            end
         end
         if (stop_p && !own) begin
            busy_ff <= 1'b0;
            if (state_ff == S_BYTE && bit_ff != 4'd0) misplaced_condition_error_ff <= 1'b1;
            else if (slv_act_ff && !supp_ff) end_detected_flag_ff <= 1'b1;
            {supp_ff, slv_act_ff, hit10_ff, tra_ff} <= 4'h0;
            if (!msl_ff) begin
               state_ff <= S_IDLE;
               {sda_oe_ff, scl_oe_ff, aph_ff} <= 3'b000;
            end
         end
      end
   end

   assign prdata_o  = prdata_ff;
   assign pready_o  = pready_ff;
   assign pslverr_o = pslverr_ff;
   assign sda_o     = zero_ff;
   assign scl_o     = zero_ff;
   assign sda_oe_o  = sda_oe_ff;
   assign scl_oe_o  = scl_oe_ff;
   assign pin_mux_o = mux_ff;
   assign irq_o     = irq_ff;
endmodule

/* File: inc/i2c_defs.vh */
/* i2c_defs.vh: register byte offsets, field positions and reset values of the i2c sequencer.
   assumes it is included by bare name from the core files; offsets are apb byte addresses. */
`ifndef I2C_DEFS_VH
`define I2C_DEFS_VH
// Operation
// - transmitter stretches SCL until byte written
// - receiver stretches SCL until byte read
// - SCL divider set by speed selection
// - compare address, ignore mismatch until start
// - 10-bit header compare, ack if enabled
// - address hit: ack, flags, stretch until status
// - direction from address bit or header
// - slave receive: ack, byte done, stretch
// - slave transmit: stretch, byte done on ack
// - addressed slave flags stop until status two
// - misplaced start or stop is bus error
// - no reply flags without stretching SCL
// - start request makes device master, stretches
// - 10-bit master header and second byte waits
// - master receive: ack, byte done, stretch
// - master transmit: stretch, byte done on ack
// - stop request ends mastership after byte
// - arbitration loss drops to slave, no stretch
// - no reply and byte done clearing rules
// - enabled pins go open drain, else gpio
`define CR_ADDR    8'h00
`define SR1_ADDR   8'h04
`define SR2_ADDR   8'h08
`define DR_ADDR    8'h0C
`define OAR1_ADDR  8'h10
`define OWN_ADDRESS_TWO_ADDR  8'h14
`define DIV_ADDR   8'h18
`define CR_ON      5
`define CR_ENGC    4
`define CR_START   3
`define CR_ACK     2
`define CR_STOP    1
`define CR_ITE     0
`define OWN_ADDRESS_TWO_FAST  7
`define OWN_ADDRESS_TWO_TEN   6
`define OAR_RST    8'h00
`define DIV_RST    8'hFF
`define GC_ADDR    8'h00
`define HDR_PAT    5'h1E
`define FILL_DATA  8'hFF
`endif

/* File: core/i2c_line_sync.v */
/* i2c_line_sync.v: two-flop synchronisers for SDA and SCL plus edge and bus condition pulses.
   assumes raw pad levels from outside the clock domain; idle bus is high. */
`timescale 1ns/1ps
module i2c_line_sync (
   input  wire mclk_i,
   input  wire rstn_i,
   input  wire sda_i,
   input  wire scl_i,
   output wire sda_s_o,
   output wire scl_s_o,
   output wire scl_rise_o,
   output wire scl_fall_o,
   output wire start_o,
   output wire stop_o
);
   reg sda_m_ff, scl_m_ff, sda_q_ff, scl_q_ff, sda_p_ff, scl_p_ff;
   reg rise_ff, fall_ff, start_ff, stop_ff;

   // first stage feeds only the second; edges compare second and third stages
   always @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         {sda_m_ff, scl_m_ff, sda_q_ff, scl_q_ff, sda_p_ff, scl_p_ff} <= 6'h3F;
         {rise_ff, fall_ff, start_ff, stop_ff} <= 4'h0;
      end else begin
         sda_m_ff <= sda_i;
         scl_m_ff <= scl_i;
         sda_q_ff <= sda_m_ff;
         scl_q_ff <= scl_m_ff;
         sda_p_ff <= sda_q_ff;
         scl_p_ff <= scl_q_ff;
         rise_ff  <= scl_q_ff & ~scl_p_ff;
         fall_ff  <= ~scl_q_ff & scl_p_ff;
         start_ff <= scl_q_ff & scl_p_ff & sda_p_ff & ~sda_q_ff;  // sda falls, scl high
         stop_ff  <= scl_q_ff & scl_p_ff & ~sda_p_ff & sda_q_ff;  // sda rises, scl high
      end
   end

   // levels delayed one stage more so they line up with the pulses
   assign sda_s_o    = sda_p_ff;
   assign scl_s_o    = scl_p_ff;
   assign scl_rise_o = rise_ff;
   assign scl_fall_o = fall_ff;
   assign start_o    = start_ff;
   assign stop_o     = stop_ff;
endmodule

/* File: core/i2c_scl_divider.v */
/* i2c_scl_divider.v: programmable divider giving one-cycle ticks every lim_i clocks.
   assumes lim_i stays stable while enabled; a zero limit acts as one. */
`timescale 1ns/1ps
module i2c_scl_divider (
   input  wire       mclk_i,
   input  wire       rstn_i,
   input  wire       en_i,
   input  wire [9:0] lim_i,
   output wire       tick_o
);
   reg  [9:0] cnt_ff;
   reg        tick_ff;
   wire [9:0] lim_m = (lim_i == 10'h000) ? 10'h001 : lim_i;

   // restarts from zero whenever disabled so the first half period is whole
   always @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cnt_ff  <= 10'h000;
         tick_ff <= 1'b0;
      end else if (!en_i) begin
         cnt_ff  <= 10'h000;
         tick_ff <= 1'b0;
      end else if (cnt_ff >= lim_m - 10'h001) begin
         cnt_ff  <= 10'h000;
         tick_ff <= 1'b1;
      end else begin
         cnt_ff  <= cnt_ff + 10'h001;
         tick_ff <= 1'b0;
      end
   end

   assign tick_o = tick_ff;
endmodule

/* File: sim/i2c_seq_properties.sv */
/* i2c_seq_properties: port checks of the sequencer.
   assumes binding onto the top module and an apb master per contract. */
`timescale 1ns/1ps
module i2c_seq_props (
   input wire logic        mclk_i, rstn_i, psel_i, penable_i,
   input wire logic [7:0]  paddr_i,
   input wire logic [31:0] prdata_o,
   input wire logic        pready_o, pslverr_o, sda_o, sda_oe_o, scl_oe_o, pin_mux_o, irq_o
);
   // single clock domain, so one default for all
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rstn_i);
   a_ready_next: assert property (psel_i && !penable_i |=> pready_o) else $error("late ready");
   a_ready_once: assert property (pready_o |=> !pready_o) else $error("ready held");
   a_ready_cause: assert property (pready_o |-> $past(psel_i && !penable_i)) else $error("stray ready");
   a_data_idle: assert property (!pready_o |-> prdata_o == 32'h0) else $error("idle data");
   a_err_unmapped: assert property (pready_o && paddr_i > 8'h18 |-> pslverr_o) else $error("no slverr");
   a_irq_on: assert property (irq_o |-> pin_mux_o) else $error("irq while off");
   a_sda_zero: assert property (sda_o == 1'b0) else $error("sda driven high");
   a_off_free: assert property (!pin_mux_o [*2] |-> !scl_oe_o && !sda_oe_o) else $error("pins held");
   c_start: cover property (irq_o && scl_oe_o);
   c_err: cover property (pslverr_o);
   c_off: cover property ($fell(pin_mux_o));
endmodule
bind i2c_multimaster_sequencer i2c_seq_props u_props (.*);

/* File: sim/i2c_slave_model.sv */
/* i2c_slave_model: behavioural target that acks its address and data, and returns a fixed byte when read.
   assumes open-drain wires with pull-ups; hold_o high pulls sda low. */
`timescale 1ns/1ps
module i2c_slave_model #(parameter logic [6:0] ADDR = 7'h50, parameter logic [7:0] DATA = 8'h5A) (
   input  wire logic scl_i,
   input  wire logic sda_i,
   output logic      hold_o,
   output logic [7:0] last_o
);
   int n = 0;
   logic [7:0] sh = 8'h00;
   logic sel = 1'b0, first = 1'b0, rw = 1'b0, rdp = 1'b0;
   initial hold_o = 1'b0;
   initial last_o = 8'h00;
   // start rearms the address phase
   always @(negedge sda_i) if (scl_i) begin n = 0; first = 1'b1; rdp = 1'b0; end
   // stop deselects so stray bytes are ignored
   always @(posedge sda_i) if (scl_i) sel = 1'b0;
   // shift on rising scl; the ninth rise is the ack slot
   always @(posedge scl_i) begin
      if (n == 8) begin
         // a master no reply ends a read; otherwise reading goes on
         n = 0;
         if (rdp && sda_i) sel = 1'b0;
         rdp = sel && rw;
      end else begin
         sh = {sh[6:0], sda_i};
         n++;
         if (n == 8 && first) begin sel = (sh[7:1] == ADDR); rw = sh[0]; first = 1'b0; end
         else if (n == 8 && sel && !rdp) last_o = sh;
      end
   end
   // ack when selected and written; when read, drive the byte and free the ack slot
   always @(negedge scl_i) hold_o <= sel && (rdp ? (n != 8 && !DATA[7 - n]) : (n == 8));
endmodule

/* File: sim/i2c_multimaster_sequencer_bench.sv */
/* i2c_multimaster_sequencer_bench: apb-driven master write and one-byte read against a slave model.
   assumes pull-ups on both wires and a 250 MHz clock. */
`timescale 1ns/1ps
module i2c_multimaster_sequencer_bench;
   logic mclk_i = 0, rstn_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0, slv;
   logic [7:0] paddr_i = 8'h00;
   logic [31:0] pwdata_i = 32'h0, rd;
   wire [31:0] prdata_o;
   wire [7:0] got;
   wire pready_o, pslverr_o, sda_o, sda_oe_o, scl_o, scl_oe_o, pin_mux_o, irq_o, hold;
   wire sda = !(sda_oe_o || hold);
   wire scl = !scl_oe_o;
   int err_count = 0, n_compared = 0;
   initial forever #2 mclk_i = ~mclk_i;
   i2c_multimaster_sequencer i_dut (.*, .sda_i(sda), .scl_i(scl));
   i2c_slave_model #(.ADDR(7'h50), .DATA(8'h5A)) u_slave (.scl_i(scl), .sda_i(sda), .hold_o(hold), .last_o(got));
   task end_of_test;
      $display("compared %0d errors %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task chk(input logic [31:0] s, e);
      n_compared++;
      if (s !== e) begin err_count++; $display("ERROR %0t seen %h want %h", $time, s, e); end
   endtask
   // an idle cycle before each setup keeps psel from two writes in one step
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge mclk_i);
      psel_i <= 1'b1; pwrite_i <= w; paddr_i <= a; pwdata_i <= d;
      @(posedge mclk_i);
      penable_i <= 1'b1;
      k = 0;
      do begin @(posedge mclk_i); k++; end while (pready_o !== 1'b1 && k < 20);
      rd = prdata_o;
      slv = pslverr_o;
      psel_i <= 1'b0; penable_i <= 1'b0;
      if (k >= 20) begin err_count++; end_of_test; end
   endtask
   // poll status one until the masked bits match
   task wt(input logic [31:0] m, v);
      int i;
      i = 0;
      do begin apb(1'b0, 8'h04, 32'h0); i++; end while ((rd & m) !== v && i < 400);
      if (i >= 400) begin err_count++; end_of_test; end
   endtask
   initial begin
      repeat (2) @(posedge mclk_i);
      rstn_i <= 1'b1;
      apb(1'b0, 8'h04, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 8'h18, 32'h0);
      chk(rd, 32'hFF);
      apb(1'b0, 8'h1C, 32'h0);
      chk(slv, 1'b1);
      apb(1'b1, 8'h00, 32'h20);
      apb(1'b1, 8'h00, 32'h25);
      chk(pin_mux_o, 1'b1);
      apb(1'b1, 8'h14, 32'h80);
      apb(1'b1, 8'h18, 32'h08);
      apb(1'b1, 8'h00, 32'h2D);
      wt(32'h83, 32'h83);
      chk(scl_oe_o, 1'b1);
      chk(irq_o, 1'b1);
      apb(1'b1, 8'h0C, 32'hA0);
      wt(32'h80, 32'h80);
      apb(1'b1, 8'h00, 32'h25);
      apb(1'b1, 8'h0C, 32'h3C);
      wt(32'h88, 32'h88);
      chk(got, 32'h3C);
      apb(1'b1, 8'h00, 32'h27);
      wt(32'h02, 32'h00);
      // single byte read: ack off before it arrives, stop set before it is read
      apb(1'b1, 8'h00, 32'h2D);
      wt(32'h83, 32'h83);
      apb(1'b1, 8'h0C, 32'hA1);
      wt(32'h80, 32'h80);
      apb(1'b1, 8'h00, 32'h21);
      wt(32'h88, 32'h88);
      chk(rd & 32'h20, 32'h0);
      apb(1'b1, 8'h00, 32'h23);
      apb(1'b0, 8'h0C, 32'h0);
      chk(rd, 32'h5A);
      wt(32'h02, 32'h00);
      apb(1'b1, 8'h00, 32'h00);
      repeat (2) @(posedge mclk_i);
      chk(pin_mux_o, 1'b0);
      end_of_test;
   end
endmodule
